//--- design/fmc_params.svh
`ifndef FMC_PARAMS_SVH
`define FMC_PARAMS_SVH

// ====================================================
// Register map
`define FMC_ADDR_CFG1 8'h00
`define FMC_ADDR_CFG2 8'h01
`define FMC_CFG1_RESET 8'h09
`define FMC_CFG2_RESET 8'h7f
// Bit 7 is self-clearing, bit 6 unused: neither is stored
`define FMC_CFG2_STORE_MASK 8'h3f

// ====================================================
// First register fields
`define FMC_C1_AUTO 7
`define FMC_C1_SRC_HI 6
`define FMC_C1_SRC_LO 5
`define FMC_C1_FAIL_EN 4
`define FMC_C1_PWM_INV 3
`define FMC_C1_TACH_ANA 2
`define FMC_C1_ALERT_EN 1
`define FMC_C1_MONITOR 0

// ====================================================
// Second register fields
`define FMC_C2_SOFT_RST 7
`define FMC_C2_UNUSED 6
`define FMC_C2_REMOTE_EN 5
`define FMC_C2_LOCAL_EN 4
`define FMC_C2_ALERT_MASK 3
`define FMC_C2_TACH_EN 2
`define FMC_C2_TMO_EN 1
`define FMC_C2_PWM_EN 0

// ====================================================
// Fan failure
`define FMC_FAIL_COUNT 5

`endif

//--- design/fmc_pkg.sv
`default_nettype none
package fmc_pkg;
    typedef logic [7:0] fmc_byte_t;

    typedef enum logic [3:0] {
        FMC_MODE_DUTY = 4'h1,
        FMC_MODE_RPM = 4'h2,
        FMC_MODE_AUTO_REMOTE = 4'h4,
        FMC_MODE_AUTO_BOTH = 4'h8
    } fmc_mode_t;
endpackage
`default_nettype wire

//--- design/fmc_fault_counter.sv
`include "fmc_params.svh"
`default_nettype none
module fmc_fault_counter #(
    parameter int COUNT = `FMC_FAIL_COUNT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic fault_event,
    input wire logic good_event,
    output logic failed
);
    localparam int CW = $clog2(COUNT + 1);

    if (COUNT < 1 || COUNT > 255) begin : g_check
        $error("fmc_fault_counter: COUNT out of range");
    end

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    wire at_limit = (cnt_reg == CW'(COUNT));

    // A fault in the same cycle as a good reading still counts
    assign cnt_next = clear ? '0 :
                      fault_event ? (at_limit ? cnt_reg : cnt_reg + 1'b1) :
                      good_event ? (at_limit ? cnt_reg : '0) :
                      cnt_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // Once reached, failure holds until cleared by reset or by the clear input
    assign failed = at_limit;

    // ====================================================
    // Assertions
    property p_five_faults;
        @(posedge clk) disable iff (reset)
        $rose(failed) |-> $past(fault_event) &&
            $past(cnt_reg) == CW'(COUNT - 1);
    endproperty
    a_five_faults: assert property (p_five_faults)
        else $error("failure flagged without enough faults");
endmodule // fmc_fault_counter
`default_nettype wire

//--- design/fmc_config_regs.sv
`include "fmc_params.svh"
`default_nettype none
module fmc_config_regs #(
    parameter int FAIL_COUNT = `FMC_FAIL_COUNT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic diode_fault_at_por,
    input wire logic fan_fault_event,
    input wire logic tach_good_event,
    input wire logic alert_req,
    input wire logic ext_alert_low,
    output fmc_pkg::fmc_mode_t fan_mode,
    output logic fan_fail_n,
    output logic pwm_active_high,
    output logic tach_analog,
    output logic alert_out_n,
    output logic monitor_active,
    output logic fan_ctrl_run,
    output logic remote_int_en,
    output logic local_int_en,
    output logic alert_in_mask,
    output logic tach_en,
    output logic bus_timeout_en,
    output logic pwm_out_en,
    output logic force_full_speed,
    output logic soft_reset_pulse
);
    if (FAIL_COUNT < 1) begin : g_check
        $error("fmc_config_regs: FAIL_COUNT must be at least 1");
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    // ====================================================
    // Decode
    logic [7:0] cfg1_reg;
    logic [7:0] cfg2_reg;
    logic por_done_reg;
    logic diode_fault_reg;
    logic armed_reg;
    logic fan_failed;

    wire wr_cfg1 = wr_en && hit(addr, `FMC_ADDR_CFG1);
    wire wr_cfg2 = wr_en && hit(addr, `FMC_ADDR_CFG2);
    wire soft_rst = wr_cfg2 && por_done_reg && wr_data[`FMC_C2_SOFT_RST];

    // Remote enable default depends on the diode check at power-up
    wire [7:0] cfg2_default = (`FMC_CFG2_RESET & `FMC_CFG2_STORE_MASK) &
        ~(8'(diode_fault_reg) << `FMC_C2_REMOTE_EN);

    wire [7:0] cfg1_next = soft_rst ? `FMC_CFG1_RESET :
                           wr_cfg1 ? wr_data : cfg1_reg;
    wire [7:0] cfg2_next = soft_rst ? cfg2_default :
                           wr_cfg2 ? (wr_data & `FMC_CFG2_STORE_MASK) :
                           cfg2_reg;

    wire [7:0] rd_mux = hit(addr, `FMC_ADDR_CFG1) ? cfg1_reg :
                        hit(addr, `FMC_ADDR_CFG2) ? cfg2_reg : 8'h00;

    wire [1:0] src = {cfg1_reg[`FMC_C1_SRC_HI], cfg1_reg[`FMC_C1_SRC_LO]};
    // Source codes 01 and 10 in automatic mode fall back to remote only
    wire fmc_pkg::fmc_mode_t mode_dec =
        cfg1_reg[`FMC_C1_AUTO] ?
            ((src == 2'h3) ? fmc_pkg::FMC_MODE_AUTO_BOTH
                           : fmc_pkg::FMC_MODE_AUTO_REMOTE) :
            (src[0] ? fmc_pkg::FMC_MODE_RPM : fmc_pkg::FMC_MODE_DUTY);

    // Fan control starts only on an explicit write of the monitor bit
    wire armed_next = soft_rst ? 1'b0 :
                      wr_cfg1 ? wr_data[`FMC_C1_MONITOR] : armed_reg;

    // ====================================================
    // Registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg1_reg <= `FMC_CFG1_RESET;
            cfg2_reg <= `FMC_CFG2_RESET & `FMC_CFG2_STORE_MASK;
            armed_reg <= 1'b0;
        end else if (!por_done_reg) begin
            cfg2_reg[`FMC_C2_REMOTE_EN] <= !diode_fault_at_por;
        end else begin
            cfg1_reg <= cfg1_next;
            cfg2_reg <= cfg2_next;
            armed_reg <= armed_next;
        end
    end

    // Diode strap is caught on the first edge after release
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            por_done_reg <= 1'b0;
            diode_fault_reg <= 1'b0;
        end else if (!por_done_reg) begin
            por_done_reg <= 1'b1;
            diode_fault_reg <= diode_fault_at_por;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= rd_mux;
            end
        end
    end

    fmc_fault_counter #(
        .COUNT(FAIL_COUNT)
    ) u_fault_counter (
        .clk(clk),
        .reset(reset),
        .clear(soft_rst),
        .fault_event(fan_fault_event),
        .good_event(tach_good_event),
        .failed(fan_failed)
    );

    // ====================================================
    // Outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fan_mode <= fmc_pkg::FMC_MODE_DUTY;
            fan_fail_n <= 1'b1;
            alert_out_n <= 1'b1;
            fan_ctrl_run <= 1'b0;
            force_full_speed <= 1'b0;
            soft_reset_pulse <= 1'b0;
        end else begin
            fan_mode <= mode_dec;
            fan_fail_n <= !(fan_failed &&
                cfg1_reg[`FMC_C1_FAIL_EN]);
            alert_out_n <= !(alert_req && cfg1_reg[`FMC_C1_ALERT_EN]);
            fan_ctrl_run <= armed_reg && cfg1_reg[`FMC_C1_MONITOR];
            // Full speed after failure applies even with the pin disabled
            force_full_speed <= fan_failed ||
                (ext_alert_low && !cfg2_reg[`FMC_C2_ALERT_MASK]);
            soft_reset_pulse <= soft_rst;
        end
    end

    assign pwm_active_high = cfg1_reg[`FMC_C1_PWM_INV];
    assign tach_analog = cfg1_reg[`FMC_C1_TACH_ANA];
    assign monitor_active = cfg1_reg[`FMC_C1_MONITOR];
    assign remote_int_en = cfg2_reg[`FMC_C2_REMOTE_EN];
    assign local_int_en = cfg2_reg[`FMC_C2_LOCAL_EN];
    assign alert_in_mask = cfg2_reg[`FMC_C2_ALERT_MASK];
    assign tach_en = cfg2_reg[`FMC_C2_TACH_EN];
    assign bus_timeout_en = cfg2_reg[`FMC_C2_TMO_EN];
    assign pwm_out_en = cfg2_reg[`FMC_C2_PWM_EN];

    // ====================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_auto_remote;
        cfg1_reg[7] && cfg1_reg[6:5] == 2'h0 |=>
            fan_mode == fmc_pkg::FMC_MODE_AUTO_REMOTE;
    endproperty
    a_auto_remote: assert property (p_auto_remote)
        else $error("auto remote mode not selected");

    property p_auto_both;
        cfg1_reg[7] && cfg1_reg[6:5] == 2'h3 |=>
            fan_mode == fmc_pkg::FMC_MODE_AUTO_BOTH;
    endproperty
    a_auto_both: assert property (p_auto_both)
        else $error("auto both-source mode not selected");

    property p_manual;
        !cfg1_reg[7] |=> (fan_mode == (cfg1_reg[5] ?
            fmc_pkg::FMC_MODE_RPM : fmc_pkg::FMC_MODE_DUTY))
            || $changed(cfg1_reg);
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual mode decode wrong");

    property p_fail_pin;
        fan_failed && cfg1_reg[4] |=> !fan_fail_n;
    endproperty
    a_fail_pin: assert property (p_fail_pin)
        else $error("fan failure pin not asserted");

    property p_fail_gated;
        !cfg1_reg[4] |=> fan_fail_n;
    endproperty
    a_fail_gated: assert property (p_fail_gated)
        else $error("fan failure pin asserted while disabled");

    property p_alert_gate;
        !cfg1_reg[1] |=> alert_out_n;
    endproperty
    a_alert_gate: assert property (p_alert_gate)
        else $error("alert asserted while disabled");

    property p_arm;
        wr_cfg1 && !soft_rst && por_done_reg && wr_data[0]
            ##1 !wr_en |=> fan_ctrl_run;
    endproperty
    a_arm: assert property (p_arm)
        else $error("fan control not started by monitor write");

    property p_soft_reset;
        soft_rst && por_done_reg |=> cfg1_reg == `FMC_CFG1_RESET &&
            cfg2_reg[4:0] == 5'(`FMC_CFG2_RESET) && soft_reset_pulse &&
            !armed_reg;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset did not restore defaults");

    property p_unused;
        !cfg2_reg[6] && !cfg2_reg[7];
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused bit reads nonzero");

    property p_diode;
        !por_done_reg && diode_fault_at_por |=> !remote_int_en;
    endproperty
    a_diode: assert property (p_diode)
        else $error("remote enable not cleared by diode fault");

    property p_alert_in;
        ext_alert_low && !cfg2_reg[3] |=> force_full_speed;
    endproperty
    a_alert_in: assert property (p_alert_in)
        else $error("alert input not honoured");

    property p_alert_pass;
        alert_req && cfg1_reg[`FMC_C1_ALERT_EN] |=> !alert_out_n;
    endproperty
    a_alert_pass: assert property (p_alert_pass)
        else $error("alert not asserted while enabled");

    property p_sleep_stop;
        !cfg1_reg[`FMC_C1_MONITOR] |=> !fan_ctrl_run;
    endproperty
    a_sleep_stop: assert property (p_sleep_stop)
        else $error("fan control running in sleep mode");

    property p_run_armed;
        fan_ctrl_run |-> $past(armed_reg);
    endproperty
    a_run_armed: assert property (p_run_armed)
        else $error("fan control running without monitor write");

    property p_cfg1_write;
        wr_cfg1 && por_done_reg |=>
            {pwm_active_high, tach_analog, monitor_active} ==
            {$past(wr_data[`FMC_C1_PWM_INV]),
             $past(wr_data[`FMC_C1_TACH_ANA]),
             $past(wr_data[`FMC_C1_MONITOR])};
    endproperty
    a_cfg1_write: assert property (p_cfg1_write)
        else $error("first register field outputs wrong after write");

    property p_cfg2_write;
        wr_cfg2 && por_done_reg && !soft_rst |=>
            {remote_int_en, local_int_en, alert_in_mask, tach_en,
             bus_timeout_en, pwm_out_en} == $past(wr_data[5:0]);
    endproperty
    a_cfg2_write: assert property (p_cfg2_write)
        else $error("second register field outputs wrong after write");

    property p_soft_pulse;
        soft_reset_pulse |-> $past(soft_rst);
    endproperty
    a_soft_pulse: assert property (p_soft_pulse)
        else $error("soft reset pulse without soft reset write");

    property p_rd_cfg1;
        rd_en && hit(addr, `FMC_ADDR_CFG1) |=>
            rd_valid && rd_data == $past(cfg1_reg);
    endproperty
    a_rd_cfg1: assert property (p_rd_cfg1)
        else $error("first register read back wrong");

    property p_rd_cfg2;
        rd_en && hit(addr, `FMC_ADDR_CFG2) |=>
            rd_valid && rd_data[7:6] == 2'h0;
    endproperty
    a_rd_cfg2: assert property (p_rd_cfg2)
        else $error("unused bits of second register read nonzero");

    property p_fail_full;
        fan_failed |=> force_full_speed;
    endproperty
    a_fail_full: assert property (p_fail_full)
        else $error("full speed not forced after fan failure");

    property p_alert_in_masked;
        ext_alert_low && cfg2_reg[`FMC_C2_ALERT_MASK] && !fan_failed |=>
            !force_full_speed;
    endproperty
    a_alert_in_masked: assert property (p_alert_in_masked)
        else $error("masked alert input forced full speed");

    c_soft_reset: cover property (soft_rst && por_done_reg);
    c_failed: cover property ($fell(fan_fail_n));
    c_run: cover property ($rose(fan_ctrl_run));
    c_auto_both: cover property (fan_mode == fmc_pkg::FMC_MODE_AUTO_BOTH);
    c_diode_fault: cover property (!por_done_reg && diode_fault_at_por);
endmodule // fmc_config_regs
`default_nettype wire

//--- verif/fmc_host_model.sv
`default_nettype none
module fmc_host_model (
    input wire logic clk,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr,
    output logic [7:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ns;

    // ====================================================
    // Single-byte accesses, launched and released at falling edges
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr_en = 1'b1;
        addr = a;
        wr_data = d;
        @(negedge clk);
        wr_en = 1'b0;
        // Released data bus shows the inverted byte, not the last byte
        wr_data = ~d;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        rd_en = 1'b1;
        addr = a;
        @(negedge clk);
        rd_en = 1'b0;
        addr = ~a;
    endtask
endmodule // fmc_host_model
`default_nettype wire

//--- verif/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wr_en, rd_en, rd_valid, diode = 1'b0;
    logic [7:0] addr, wr_data, rd_data, d;
    logic fault = 1'b0, good = 1'b0, alert_req = 1'b0, ext_low = 1'b0;
    logic fail_n, pwm_hi, tach_ana, alert_n, mon, run, rem_en, loc_en;
    logic mask, tach_en, tmo_en, pwm_en, full, srst;
    fmc_pkg::fmc_mode_t mode;
    fmc_pkg::fmc_mode_t modes[4] = '{fmc_pkg::FMC_MODE_AUTO_REMOTE,
        fmc_pkg::FMC_MODE_AUTO_BOTH, fmc_pkg::FMC_MODE_DUTY,
        fmc_pkg::FMC_MODE_RPM};
    logic [7:0] mode_val[4] = '{8'h81, 8'he1, 8'h01, 8'h21};
    logic [7:0] exp_q[$];
    int n_fail = 0, n_compared = 0, cycles = 0;

    always #50 clk = ~clk;

    fmc_host_model fmc_host_model_inst (.clk(clk), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wr_data(wr_data));

    fmc_config_regs fmc_config_regs_inst (.clk(clk),
        .reset(reset), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .diode_fault_at_por(diode), .fan_fault_event(fault),
        .tach_good_event(good), .alert_req(alert_req),
        .ext_alert_low(ext_low), .fan_mode(mode), .fan_fail_n(fail_n),
        .pwm_active_high(pwm_hi), .tach_analog(tach_ana),
        .alert_out_n(alert_n), .monitor_active(mon), .fan_ctrl_run(run),
        .remote_int_en(rem_en), .local_int_en(loc_en),
        .alert_in_mask(mask), .tach_en(tach_en), .bus_timeout_en(tmo_en),
        .pwm_out_en(pwm_en), .force_full_speed(full),
        .soft_reset_pulse(srst));

    // ====================================================
    // Checking
    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Read data is judged by the watcher against the oldest note
    always @(negedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0)
                check("unexpected read", rd_data, 8'hxx);
            else
                check("read data", rd_data, exp_q.pop_front());
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        fmc_host_model_inst.rd(a);
    endtask

    task automatic ev(input logic f, input logic g);
        fault = f;
        good = g;
        @(negedge clk);
        fault = 1'b0;
        good = 1'b0;
    endtask

    task automatic waitc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ====================================================
    // Main sequence
    initial begin
        void'($urandom(32'h7501));
        waitc(12);
        reset = 1'b0;
        waitc(2);
        rd_chk(8'h00, 8'h09);
        rd_chk(8'h01, 8'h3f);
        check("monitor", {7'h00, mon}, 8'h01);
        check("fan run", {7'h00, run}, 8'h00);
        $display("test reset values done");

        for (int i = 0; i < 4; i++) begin
            fmc_host_model_inst.wr(8'h00, mode_val[i]);
            waitc(1);
            check("fan mode", {4'h0, mode},
                  {4'h0, modes[i]});
            check("fan run", {7'h00, run}, 8'h01);
        end
        $display("test fan modes done");

        repeat (8) begin
            d = 8'($urandom());
            fmc_host_model_inst.wr(8'h00, d);
            check("cfg1 bits", {4'h0, pwm_hi, tach_ana, 1'b0, mon},
                  {4'h0, d[3], d[2], 1'b0, d[0]});
            rd_chk(8'h00, d);
            d = 8'($urandom()) & 8'h7f;
            fmc_host_model_inst.wr(8'h01, d);
            check("cfg2 bits",
                  {2'h0, rem_en, loc_en, mask, tach_en, tmo_en, pwm_en},
                  d & 8'h3f);
            rd_chk(8'h01, d & 8'h3f);
        end
        $display("test random registers done");

        fmc_host_model_inst.wr(8'h00, 8'h13);
        fmc_host_model_inst.wr(8'h01, 8'h37);
        alert_req = 1'b1;
        waitc(2);
        check("alert out", {7'h00, alert_n}, 8'h00);
        alert_req = 1'b0;
        ext_low = 1'b1;
        waitc(2);
        check("full speed", {7'h00, full}, 8'h01);
        ext_low = 1'b0;
        waitc(2);
        check("full speed", {7'h00, full}, 8'h00);
        fmc_host_model_inst.wr(8'h01, 8'h3f);
        ext_low = 1'b1;
        waitc(2);
        check("full speed", {7'h00, full}, 8'h00);
        ext_low = 1'b0;
        ev(1'b1, 1'b0);
        ev(1'b0, 1'b1);
        repeat (4) ev(1'b1, 1'b0);
        waitc(2);
        check("fail pin", {7'h00, fail_n}, 8'h01);
        ev(1'b1, 1'b0);
        waitc(2);
        check("fail pin", {7'h00, fail_n}, 8'h00);
        check("full speed", {7'h00, full}, 8'h01);
        fmc_host_model_inst.wr(8'h00, 8'h03);
        waitc(1);
        check("fail pin", {7'h00, fail_n}, 8'h01);
        check("full speed", {7'h00, full}, 8'h01);
        fmc_host_model_inst.wr(8'h00, 8'h13);
        waitc(1);
        check("fail pin", {7'h00, fail_n}, 8'h00);
        $display("test faults and alert done");

        fmc_host_model_inst.wr(8'h01, 8'h80);
        check("soft reset", {7'h00, srst}, 8'h01);
        waitc(1);
        check("fail pin", {7'h00, fail_n}, 8'h01);
        check("fan run", {7'h00, run}, 8'h00);
        check("full speed", {7'h00, full}, 8'h00);
        rd_chk(8'h00, 8'h09);
        rd_chk(8'h01, 8'h3f);
        rd_chk(8'h05, 8'h00);
        $display("test soft reset done");

        diode = 1'b1;
        reset = 1'b1;
        waitc(1);
        reset = 1'b0;
        waitc(2);
        rd_chk(8'h01, 8'h1f);
        waitc(3);
        $display("test diode fault done");
        check("pending reads", 8'(exp_q.size()), 8'h00);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
